//--- lfb_receiver.sv
// lf telegram baseband: preamble/sync hunt, manchester decode, word buffer, apb registers
// assumes man_data_i is synchronous to clk_sys_i and an apb master on the bus side
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module lfb_receiver #(
    parameter int unsigned HALF_BIT_CYC = lfb_pkg::HALF_BIT_CYC
) (
    // clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 nrst_i,
    // apb slave
    input  wire lfb_pkg::lfb_apb_req_t apb_i,
    output logic [31:0]               prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // front end
    input  wire logic                 man_data_i,
    output logic                      afe_enable_o,
    // system
    output logic                      cpu_power_up_o,
    output logic                      irq_o
);
    localparam logic [15:0] H   = 16'(HALF_BIT_CYC);
    localparam logic [15:0] Q   = H >> 1;
    localparam logic [15:0] Q3  = H + Q;
    localparam logic [15:0] BIT = (H << 1) - 16'h0001;

    // ======================================================
    // interval classifier, in half-bit units
    function automatic logic [1:0] classify(input logic [15:0] c);
        if (c < Q)
            classify = 2'h0;
        else if (c < Q3)
            classify = lfb_pkg::CLS_SHORT;
        else if (c < (H << 1) + Q)
            classify = lfb_pkg::CLS_LONG;
        else if (c < (H << 1) + Q3)
            classify = lfb_pkg::CLS_SYNC;
        else
            classify = 2'h0;
    endfunction

    // ======================================================
    // register group
    logic [7:0]  ctrl_r, ctrl_nxt, maxw_r, maxw_nxt, wkh_r, wkh_nxt, wkl_r, wkl_nxt;
    logic [7:0]  onc_r, onc_nxt, offh_r, offh_nxt, offl_r, offl_nxt;
    logic [7:0]  flags_r, flags_nxt, mask_r, mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, perr_r, perr_nxt, irq_r, irq_nxt;
    // receiver events, one cycle each
    logic        ev_sync, ev_word, ev_end, ev_err, ev_wake, cap_hit;

    logic        acc, wr;
    logic [7:0]  rd8;
    logic        hit;
    logic        rx_en, listen_en, wake_en;

    // ======================================================
    // receiver group
    lfb_pkg::lfb_state_t st_r, st_nxt;
    lfb_pkg::lfb_rx_word_t word_r, word_nxt;
    logic        din_r, din_nxt;
    logic [15:0] ecnt_r, ecnt_nxt, pcnt_r, pcnt_nxt, tick_r, tick_nxt, lcnt_r, lcnt_nxt;
    logic [7:0]  pre_r, pre_nxt, shf_r, shf_nxt, hi_r, hi_nxt, wcnt_r, wcnt_nxt;
    logic [2:0]  bcnt_r, bcnt_nxt;
    logic        bsel_r, bsel_nxt, s1_r, s1_nxt, s2_r, s2_nxt, lon_r, lon_nxt, pwr_r, pwr_nxt;
    logic        edge_seen, asleep, bit_v;
    logic [1:0]  cls;
    logic [7:0]  byte_v;

    assign rx_en     = ctrl_r[lfb_pkg::CTRL_RX_EN];
    assign listen_en = ctrl_r[lfb_pkg::CTRL_LISTEN_EN];
    assign wake_en   = ctrl_r[lfb_pkg::CTRL_WAKE_EN];

    always_comb begin
        acc = apb_i.psel & apb_i.penable;
        wr  = acc & pready_r & apb_i.pwrite;
        hit = 1'b1;
        unique case (apb_i.paddr)
            lfb_pkg::OFS_CTRL:      rd8 = ctrl_r;
            lfb_pkg::OFS_MAXWORD:   rd8 = maxw_r;
            lfb_pkg::OFS_WAKE_HI:   rd8 = wkh_r;
            lfb_pkg::OFS_WAKE_LO:   rd8 = wkl_r;
            lfb_pkg::OFS_ON_CNT:    rd8 = onc_r;
            lfb_pkg::OFS_OFF_HI:    rd8 = offh_r;
            lfb_pkg::OFS_OFF_LO:    rd8 = offl_r;
            lfb_pkg::OFS_RXW_HI:    rd8 = word_r.rx_word_high;
            lfb_pkg::OFS_RXW_LO:    rd8 = word_r.rx_word_low;
            lfb_pkg::OFS_IRQ_FLAGS: rd8 = flags_r;
            lfb_pkg::OFS_IRQ_MASK:  rd8 = mask_r;
            lfb_pkg::OFS_STATUS:    rd8 = {lon_r, pwr_r, 3'h0, 3'(st_r)};
            default: begin
                rd8 = 8'h00;
                hit = 1'b0;
            end
        endcase
        // one wait state so read data leaves a flip-flop
        pready_nxt = acc & ~pready_r;
        perr_nxt   = acc & ~pready_r & ~hit;
        prdata_nxt = (acc & ~pready_r & ~apb_i.pwrite) ? {24'h000000, rd8} : prdata_r;
        ctrl_nxt   = ctrl_r;
        maxw_nxt   = maxw_r;
        wkh_nxt    = wkh_r;
        wkl_nxt    = wkl_r;
        onc_nxt    = onc_r;
        offh_nxt   = offh_r;
        offl_nxt   = offl_r;
        mask_nxt   = mask_r;
        flags_nxt  = flags_r;
        if (wr) begin
            unique case (apb_i.paddr)
                lfb_pkg::OFS_CTRL:      ctrl_nxt  = apb_i.pwdata[7:0];
                lfb_pkg::OFS_MAXWORD:   maxw_nxt  = apb_i.pwdata[7:0];
                lfb_pkg::OFS_WAKE_HI:   wkh_nxt   = apb_i.pwdata[7:0];
                lfb_pkg::OFS_WAKE_LO:   wkl_nxt   = apb_i.pwdata[7:0];
                lfb_pkg::OFS_ON_CNT:    onc_nxt   = apb_i.pwdata[7:0];
                lfb_pkg::OFS_OFF_HI:    offh_nxt  = apb_i.pwdata[7:0];
                lfb_pkg::OFS_OFF_LO:    offl_nxt  = apb_i.pwdata[7:0];
                lfb_pkg::OFS_IRQ_FLAGS: flags_nxt = flags_r & ~apb_i.pwdata[7:0];
                lfb_pkg::OFS_IRQ_MASK:  mask_nxt  = apb_i.pwdata[7:0];
                default:                flags_nxt = flags_r;
            endcase
        end
        // hardware set wins over a same-cycle clear
        if (ev_sync)
            flags_nxt[lfb_pkg::FLG_SYNC] = 1'b1;
        if (ev_end)
            flags_nxt[lfb_pkg::FLG_END] = 1'b1;
        if (ev_err)
            flags_nxt[lfb_pkg::FLG_ERR] = 1'b1;
        if (ev_wake)
            flags_nxt[lfb_pkg::FLG_WAKE] = 1'b1;
        if (ev_word)
            flags_nxt[lfb_pkg::FLG_RDY] = 1'b1;
        irq_nxt = |(flags_nxt & mask_r);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ctrl_r   <= lfb_pkg::CTRL_RST;
            maxw_r   <= lfb_pkg::MAXWORD_RST;
            wkh_r    <= 8'h00;
            wkl_r    <= 8'h00;
            onc_r    <= lfb_pkg::ON_CNT_RST;
            offh_r   <= 8'h00;
            offl_r   <= lfb_pkg::OFF_CNT_RST;
            flags_r  <= 8'h00;
            mask_r   <= 8'h00;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            perr_r   <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            maxw_r   <= maxw_nxt;
            wkh_r    <= wkh_nxt;
            wkl_r    <= wkl_nxt;
            onc_r    <= onc_nxt;
            offh_r   <= offh_nxt;
            offl_r   <= offl_nxt;
            flags_r  <= flags_nxt;
            mask_r   <= mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            perr_r   <= perr_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign prdata_o       = prdata_r;
    assign pready_o       = pready_r;
    assign pslverr_o      = perr_r;
    assign irq_o          = irq_r;
    assign cpu_power_up_o = pwr_r;
    // duty cycling only while idle; an active telegram keeps the front end up
    assign asleep       = listen_en & ~lon_r & (st_r == lfb_pkg::ST_HUNT) & (pre_r == 8'h00);
    assign afe_enable_o = rx_en & ~asleep;

    always_comb begin
        din_nxt   = man_data_i;
        edge_seen = (man_data_i != din_r) & rx_en & ~asleep;
        cls       = classify(ecnt_r);
        st_nxt    = st_r;
        word_nxt  = word_r;
        ecnt_nxt  = edge_seen ? 16'h0000 : ((ecnt_r == 16'hFFFF) ? ecnt_r : ecnt_r + 16'h0001);
        pcnt_nxt  = pcnt_r;
        pre_nxt   = pre_r;
        shf_nxt   = shf_r;
        hi_nxt    = hi_r;
        wcnt_nxt  = wcnt_r;
        bcnt_nxt  = bcnt_r;
        bsel_nxt  = bsel_r;
        s1_nxt    = s1_r;
        s2_nxt    = s2_r;
        pwr_nxt   = pwr_r & wake_en;
        ev_sync   = 1'b0;
        ev_word   = 1'b0;
        ev_end    = 1'b0;
        ev_err    = 1'b0;
        ev_wake   = 1'b0;
        cap_hit   = 1'b0;
        bit_v     = s2_r;
        byte_v    = {shf_r[6:0], s2_r};
        // listen duty cycle, counted in whole bit periods
        tick_nxt  = (tick_r == BIT) ? 16'h0000 : tick_r + 16'h0001;
        lon_nxt   = lon_r;
        lcnt_nxt  = lcnt_r;
        if (!listen_en) begin
            lon_nxt  = 1'b1;
            lcnt_nxt = 16'h0000;
        end else if (tick_r == BIT) begin
            lcnt_nxt = lcnt_r + 16'h0001;
            if (lon_r && lcnt_r >= {8'h00, onc_r}) begin
                lon_nxt  = 1'b0;
                lcnt_nxt = 16'h0000;
            end else if (!lon_r && lcnt_r >= {offh_r, offl_r}) begin
                lon_nxt  = 1'b1;
                lcnt_nxt = 16'h0000;
            end
        end
        unique case (st_r)
            lfb_pkg::ST_HUNT: begin
                if (!rx_en || asleep) begin
                    pre_nxt = 8'h00;
                end else if (edge_seen) begin
                    if (cls == lfb_pkg::CLS_SHORT || cls == lfb_pkg::CLS_LONG) begin
                        pre_nxt = (pre_r == 8'hFF) ? pre_r : pre_r + 8'h01;
                    end else if (cls == lfb_pkg::CLS_SYNC && pre_r >= lfb_pkg::PREAMBLE_MIN) begin
                        st_nxt = lfb_pkg::ST_SYNC;
                    end else begin
                        pre_nxt = 8'h00;
                    end
                end
            end
            lfb_pkg::ST_SYNC: begin
                if (edge_seen && cls == lfb_pkg::CLS_SYNC) begin
                    st_nxt   = lfb_pkg::ST_DATA;
                    ev_sync  = 1'b1;
                    pcnt_nxt = 16'h0000;
                    bcnt_nxt = 3'h0;
                    bsel_nxt = 1'b0;
                    wcnt_nxt = 8'h00;
                end else if (edge_seen || ecnt_r == 16'hFFFF || !rx_en) begin
                    st_nxt  = lfb_pkg::ST_HUNT;
                    pre_nxt = 8'h00;
                end
            end
            lfb_pkg::ST_DATA: begin
                pcnt_nxt = pcnt_r + 16'h0001;
                if (pcnt_r == Q)
                    s1_nxt = din_r;
                if (pcnt_r == Q3)
                    s2_nxt = din_r;
                // mid-bit edge realigns the cell timing
                if (edge_seen && pcnt_r > Q && pcnt_r < Q3)
                    pcnt_nxt = H;
                if (pcnt_r == BIT) begin
                    pcnt_nxt = 16'h0000;
                    if (s1_r == s2_r) begin
                        st_nxt  = lfb_pkg::ST_HUNT;
                        pre_nxt = 8'h00;
                        ev_end  = (bcnt_r == 3'h0);
                        ev_err  = (bcnt_r != 3'h0);
                    end else begin
                        shf_nxt  = {shf_r[6:0], bit_v};
                        bcnt_nxt = bcnt_r + 3'h1;
                        if (bcnt_r == 3'h7) begin
                            bsel_nxt = ~bsel_r;
                            if (!bsel_r) begin
                                hi_nxt = byte_v;
                            end else begin
                                ev_word  = 1'b1;
                                word_nxt = '{rx_word_high: hi_r, rx_word_low: byte_v};
                                wcnt_nxt = wcnt_r + 8'h01;
                                if (wcnt_r == 8'h00 && wake_en && {hi_r, byte_v} == {wkh_r, wkl_r}) begin
                                    ev_wake = 1'b1;
                                    pwr_nxt = 1'b1;
                                end
                                cap_hit = (maxw_r != 8'h00) && (wcnt_r + 8'h01 == maxw_r);
                                if (cap_hit) begin
                                    st_nxt  = lfb_pkg::ST_HUNT;
                                    pre_nxt = 8'h00;
                                    ev_end  = 1'b1;
                                end
                            end
                        end
                    end
                end
                if (!rx_en) begin
                    st_nxt  = lfb_pkg::ST_HUNT;
                    pre_nxt = 8'h00;
                end
            end
            default: begin
                st_nxt  = lfb_pkg::ST_HUNT;
                pre_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_r   <= lfb_pkg::ST_HUNT;
            word_r <= '0;
            din_r  <= 1'b0;
            ecnt_r <= 16'h0000;
            pcnt_r <= 16'h0000;
            tick_r <= 16'h0000;
            lcnt_r <= 16'h0000;
            pre_r  <= 8'h00;
            shf_r  <= 8'h00;
            hi_r   <= 8'h00;
            wcnt_r <= 8'h00;
            bcnt_r <= 3'h0;
            bsel_r <= 1'b0;
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            lon_r  <= 1'b1;
            pwr_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            word_r <= word_nxt;
            din_r  <= din_nxt;
            ecnt_r <= ecnt_nxt;
            pcnt_r <= pcnt_nxt;
            tick_r <= tick_nxt;
            lcnt_r <= lcnt_nxt;
            pre_r  <= pre_nxt;
            shf_r  <= shf_nxt;
            hi_r   <= hi_nxt;
            wcnt_r <= wcnt_nxt;
            bcnt_r <= bcnt_nxt;
            bsel_r <= bsel_nxt;
            s1_r   <= s1_nxt;
            s2_r   <= s2_nxt;
            lon_r  <= lon_nxt;
            pwr_r  <= pwr_nxt;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence s_word_done;
        ev_word ##1 flags_r[lfb_pkg::FLG_RDY];
    endsequence

    a_data_after_sync: assert property ($rose(st_r == lfb_pkg::ST_DATA) |-> $past(ev_sync))
        else $error("data phase entered without sync");
    a_sync_after_pre: assert property ($rose(st_r == lfb_pkg::ST_SYNC) |-> $past(pre_r) >= lfb_pkg::PREAMBLE_MIN)
        else $error("sync hunt entered on short preamble");
    a_ready_set: assert property (ev_word |-> s_word_done)
        else $error("ready flag not set after word");
    a_ready_sticky: assert property (flags_r[lfb_pkg::FLG_RDY] && !wr |=> flags_r[lfb_pkg::FLG_RDY])
        else $error("ready flag dropped without clear");
    a_word_stable: assert property (!ev_word |=> $stable(word_r))
        else $error("word changed without new word");
    a_byte_order: assert property (ev_word |=> word_r.rx_word_high == $past(hi_r))
        else $error("first byte not in high register");
    a_word_cap: assert property (ev_word && cap_hit |=> st_r == lfb_pkg::ST_HUNT ##1 !ev_word [*4])
        else $error("words accepted past cap");
    a_end_boundary: assert property (ev_end && !cap_hit |-> bcnt_r == 3'h0 && s1_r == s2_r)
        else $error("end seen off byte boundary");
    a_wake_power: assert property (ev_wake |=> cpu_power_up_o && flags_r[lfb_pkg::FLG_WAKE])
        else $error("wake match did not power up");
    a_listen_off: assert property (asleep |-> !afe_enable_o && !edge_seen)
        else $error("front end on during off time");
endmodule
`default_nettype wire

//--- lfb_pkg.sv
// constants, types and register map of the lf telegram baseband receiver
// assumes one 100 MHz system clock and an apb master for software access
// Function
// - message judged only from sliced front-end data
// - manchester preamble starts a candidate message
// - non-manchester sync pattern ends the preamble
// - no data stored before a valid sync
// - 16-bit wake identifier then data bytes follow
// - identifier and bytes decoded as manchester symbols
// - bytes paired into words, ready flag bit 5
// - stop after programmed word count, identifier included
// - illegal bit at byte boundary ends message
// - wake enable compares identifier, powers up cpu
// - listen circuitry duty-cycled by on/off counts
package lfb_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam real         BIT_RATE_KBPS  = 3.906;
    localparam int unsigned HALF_BIT_CYC   = int'(real'(CLK_HZ) / (BIT_RATE_KBPS * 2000.0));
    localparam logic [7:0]  PREAMBLE_MIN   = 8'h08;
    localparam logic [1:0]  CLS_SHORT      = 2'h1;
    localparam logic [1:0]  CLS_LONG       = 2'h2;
    localparam logic [1:0]  CLS_SYNC       = 2'h3;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_MAXWORD    = 8'h04;
    localparam logic [7:0]  OFS_WAKE_HI    = 8'h08;
    localparam logic [7:0]  OFS_WAKE_LO    = 8'h0C;
    localparam logic [7:0]  OFS_ON_CNT     = 8'h10;
    localparam logic [7:0]  OFS_OFF_HI     = 8'h14;
    localparam logic [7:0]  OFS_OFF_LO     = 8'h18;
    localparam logic [7:0]  OFS_RXW_HI     = 8'h1C;
    localparam logic [7:0]  OFS_RXW_LO     = 8'h20;
    localparam logic [7:0]  OFS_IRQ_FLAGS  = 8'h24;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h28;
    localparam logic [7:0]  OFS_STATUS     = 8'h2C;
    // ==========================================================
    // field positions and reset values
    localparam int unsigned CTRL_RX_EN     = 0;
    localparam int unsigned CTRL_LISTEN_EN = 1;
    localparam int unsigned CTRL_WAKE_EN   = 4;
    localparam int unsigned FLG_SYNC       = 0;
    localparam int unsigned FLG_END        = 1;
    localparam int unsigned FLG_WAKE       = 2;
    localparam int unsigned FLG_ERR        = 3;
    localparam int unsigned FLG_RDY        = 5;
    localparam logic [7:0]  CTRL_RST       = 8'h01;
    localparam logic [7:0]  MAXWORD_RST    = 8'h04;
    localparam logic [7:0]  ON_CNT_RST     = 8'h08;
    localparam logic [7:0]  OFF_CNT_RST    = 8'h40;
    typedef enum logic [2:0] {ST_HUNT, ST_SYNC, ST_DATA} lfb_state_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lfb_apb_req_t;
    typedef struct packed {
        logic [7:0] rx_word_high;
        logic [7:0] rx_word_low;
    } lfb_rx_word_t;
endpackage

//--- lfb_afe_model.sv
// behavioural front end: sliced manchester telegrams as a base station sends them
// assumes the caller enters each task just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module lfb_afe_model #(
    parameter int unsigned H = 16
) (
    input  wire logic clk_sys_i,
    output logic      man_data_o
);
    initial man_data_o = 1'b0;
    task automatic hold(input logic v, input int unsigned n);
        man_data_o <= v;
        repeat (n) @(posedge clk_sys_i);
    endtask
    // ==========================================================
    // preamble, sync, cells
    // more edges than the receiver's minimum, so its slicer can settle
    task automatic preamble(input int n);
        for (int i = 0; i < n; i++) hold(~man_data_o, H);
    endtask
    // level is steered so the closing edge is the start of bit 0
    task automatic sync(input logic b0);
        if (man_data_o !== b0) hold(b0, H);
        hold(~b0, 3 * H);
        hold(b0, 3 * H);
    endtask
    task automatic bits(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            hold(~v[i], H);
            hold(v[i], H);
        end
    endtask
    // equal halves; line then stays quiet past a sync interval so the
    // next preamble's first edge cannot pair with this cell as sync
    task automatic illegal();
        hold(~man_data_o, 3 * H);
        repeat (4 * H) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

//--- lfb_receiver_test.sv
// self-checking bench of the lf telegram receiver: apb driver, word scoreboard
// assumes lfb_afe_model feeds man_data_i; half bit shortened to H cycles
`timescale 1ns/100ps
`default_nettype none
module lfb_receiver_test;
    localparam int unsigned H = 16;
    logic                  clk_sys_i;
    logic                  nrst_i;
    lfb_pkg::lfb_apb_req_t apb_r;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  man_data;
    logic                  afe_en;
    logic                  cpu_up;
    logic                  irq;
    logic                  last_err;
    logic                  mon_busy;
    logic [31:0]           seed;
    logic [15:0]           last_w;
    int                    num_errors = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    lfb_pkg::lfb_rx_word_t exp_q[$];
    localparam logic [7:0] RST_TBL [7] = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h08, 8'h00, 8'h40};
    lfb_receiver #(.HALF_BIT_CYC(H)) lfb_receiver_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .apb_i(apb_r), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .man_data_i(man_data),
        .afe_enable_o(afe_en), .cpu_power_up_o(cpu_up), .irq_o(irq));
    lfb_afe_model #(.H(H)) lfb_afe_model_inst (.clk_sys_i(clk_sys_i), .man_data_o(man_data));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        tests_run++;
        if (seen !== expd) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one extra edge after release keeps back-to-back calls from colliding
    // waits for pready however long it takes; only the cycle ceiling ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        apb_r.penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        apb_r <= '0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        apb(1'b1, a, d, t);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // identifier word, nw random words, end cell; words past cap not expected
    task automatic send_msg(input logic [15:0] id, input int nw, input int cap);
        logic [15:0] w;
        lfb_afe_model_inst.preamble(10);
        lfb_afe_model_inst.sync(id[15]);
        for (int i = 0; i <= nw; i++) begin
            seed = xs(seed);
            w = (i == 0) ? id : seed[15:0];
            if (i < cap) exp_q.push_back(lfb_pkg::lfb_rx_word_t'(w));
            if (i < cap) last_w = w;
            lfb_afe_model_inst.bits(w, 16);
        end
        lfb_afe_model_inst.illegal();
        while (mon_busy) @(posedge clk_sys_i);
    endtask
    // ==========================================================
    // word monitor: pops the oldest note when ready raises irq
    initial begin : monitor
        lfb_pkg::lfb_rx_word_t e;
        logic [31:0] h;
        logic [31:0] l;
        mon_busy = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (irq === 1'b1) begin
                mon_busy = 1'b1;
                apb(1'b0, lfb_pkg::OFS_IRQ_FLAGS, 32'h0, h);
                check(h & 32'h20, 32'h20);
                apb(1'b0, lfb_pkg::OFS_RXW_HI, 32'h0, h);
                apb(1'b0, lfb_pkg::OFS_RXW_LO, 32'h0, l);
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF;
                check({h[23:0], l[7:0]}, {16'h0, e});
                apb(1'b1, lfb_pkg::OFS_IRQ_FLAGS, 32'h20, h);
                mon_busy = 1'b0;
            end
        end
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            conclude();
        end
    end
    // ==========================================================
    // main sequence
    initial begin : main
        logic [31:0] r;
        nrst_i = 1'b0;
        apb_r = '0;
        seed = 32'h9AE4;
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        check({cpu_up, irq, afe_en}, 32'h1);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, r);
            check(r, {24'h0, RST_TBL[i]});
        end
        apb(1'b0, 8'h30, 32'h0, r);
        check({r[30:0], last_err}, 32'h1);
        $display("test registers done");
        wr(lfb_pkg::OFS_IRQ_MASK, 32'h20);
        lfb_afe_model_inst.preamble(10);
        lfb_afe_model_inst.bits(16'hA5C3, 16);
        apb(1'b0, lfb_pkg::OFS_IRQ_FLAGS, 32'h0, r);
        check(r & 32'h21, 32'h0);
        $display("test no sync done");
        seed = xs(seed);
        wr(lfb_pkg::OFS_WAKE_HI, {24'h0, seed[15:8]});
        wr(lfb_pkg::OFS_WAKE_LO, {24'h0, seed[7:0]});
        wr(lfb_pkg::OFS_CTRL, 32'h11);
        send_msg(seed[15:0], 2, 4);
        apb(1'b0, lfb_pkg::OFS_IRQ_FLAGS, 32'h0, r);
        check(r & 32'h0F, 32'h07);
        check({31'h0, cpu_up}, 32'h1);
        check(32'(exp_q.size()), 32'h0);
        apb(1'b0, lfb_pkg::OFS_RXW_HI, 32'h0, r);
        check(r, {24'h0, last_w[15:8]});
        wr(lfb_pkg::OFS_IRQ_FLAGS, 32'h0F);
        wr(lfb_pkg::OFS_CTRL, 32'h01);
        repeat (2) @(posedge clk_sys_i);
        check({31'h0, cpu_up}, 32'h0);
        $display("test wake telegram done");
        wr(lfb_pkg::OFS_MAXWORD, 32'h02);
        wr(lfb_pkg::OFS_CTRL, 32'h11);
        send_msg(seed[15:0] ^ 16'h0001, 3, 2);
        apb(1'b0, lfb_pkg::OFS_IRQ_FLAGS, 32'h0, r);
        check(r & 32'h0F, 32'h03);
        check({31'h0, cpu_up}, 32'h0);
        check(32'(exp_q.size()), 32'h0);
        wr(lfb_pkg::OFS_IRQ_FLAGS, 32'h0F);
        $display("test word cap done");
        lfb_afe_model_inst.preamble(10);
        lfb_afe_model_inst.sync(1'b1);
        lfb_afe_model_inst.bits(16'h000B, 4);
        lfb_afe_model_inst.illegal();
        apb(1'b0, lfb_pkg::OFS_IRQ_FLAGS, 32'h0, r);
        check(r & 32'h2A, 32'h08);
        wr(lfb_pkg::OFS_IRQ_FLAGS, 32'h0F);
        $display("test mid byte error done");
        wr(lfb_pkg::OFS_ON_CNT, 32'h0);
        wr(lfb_pkg::OFS_OFF_LO, 32'h1);
        wr(lfb_pkg::OFS_CTRL, 32'h03);
        for (int i = 0; i < 400 && afe_en !== 1'b0; i++) @(posedge clk_sys_i);
        r = 0;
        while (afe_en === 1'b0 && r < 400) begin
            @(posedge clk_sys_i);
            r++;
        end
        check(r, 32'(4 * H));
        $display("test listen cycling done");
        conclude();
    end
endmodule
`default_nettype wire
